// ### include/blp_cfg.svh
`ifndef BLP_CFG_SVH
`define BLP_CFG_SVH
`define BLP_CLK_HZ 250000000
`define BLP_BAUD 9600
`define BLP_BAUD_DIV (`BLP_CLK_HZ / `BLP_BAUD)
`define BLP_FLASH_MS 250
`define BLP_FLASH_DIV (`BLP_CLK_HZ / 1000 * `BLP_FLASH_MS)
`define BLP_FRAME_BITS 4'h9
`define BLP_LAST_DATA_BIT 4'h8
`define BLP_REC_BYTES 3'h6
`define BLP_GROUP_BYTES 3'h4
`define BLP_LAST_IDX 2'h3
`define BLP_START_WAIT 2'h3
`define BLP_EXEC_BIT 7
`define BLP_OTP_ERASED 8'h00
`define BLP_EE_ERASED 8'hff
`define BLP_RAM1_LO 16'h0050
`define BLP_RSV_HI 16'h008a
`define BLP_RAM1_HI 16'h00ff
`define BLP_EE_LO 16'h0100
`define BLP_EE_HI 16'h01ff
`define BLP_RAM2_LO 16'h0250
`define BLP_RAM2_HI 16'h02ff
`define BLP_USER_EXEC_ADDRESS 16'h008b
`define BLP_RAM_START 16'h0050
`define BLP_PVEC_BASE 16'h02ee
`define BLP_PVEC_STEP 16'h0003
`define BLP_RAM_AW 10
`define BLP_RAM_DEPTH 1024
`endif

// ### include/blp_pkg.sv
package blp_pkg;
    typedef enum logic [8:0] {
        S_START = 9'h001,
        S_VERIFY = 9'h002,
        S_REFUSE = 9'h004,
        S_SER = 9'h008,
        S_PCHK = 9'h010,
        S_PREQ = 9'h020,
        S_PREL = 9'h040,
        S_RUN = 9'h080,
        S_HALT = 9'h100
    } blp_state_e;
    typedef enum logic [2:0] {P_IDLE = 3'h1, P_STEP = 3'h2, P_WAIT = 3'h4} blp_prog_e;
    typedef enum logic [1:0] {RG_OTP = 2'h0, RG_EE = 2'h1, RG_RAM = 2'h2} blp_region_e;
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] data;
    } blp_nv_s;
    typedef struct packed {
        logic boot;
        logic loopExit;
        logic loaderSel;
        logic secure;
    } blp_strap_s;
    typedef logic [3:0][7:0] blp_group_t;
endpackage

// ### core/blp_ram.sv
`timescale 1ns/10ps
`default_nettype none
`include "blp_cfg.svh"
module blp_ram (
    input wire logic clk,
    input wire logic we,
    input wire logic [`BLP_RAM_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [`BLP_RAM_AW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [`BLP_RAM_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ### core/blp_uart.sv
`timescale 1ns/10ps
`default_nettype none
`include "blp_cfg.svh"
module blp_uart #(
    parameter int unsigned BAUD_DIV = `BLP_BAUD_DIV
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rxPin,
    input wire logic txStart,
    input wire logic [7:0] txByte,
    output logic txPin,
    output logic txReady,
    output logic rxValid,
    output logic [7:0] rxByte
);
    localparam logic [15:0] FULL = 16'(BAUD_DIV - 1);
    localparam logic [15:0] HALF = 16'(BAUD_DIV / 2);
    logic rxS1_q, rxS2_q, rxBusy_q, rxBusy_d, rxValid_d;
    logic [3:0] rxBit_q, rxBit_d, txBits_q, txBits_d;
    logic [15:0] rxCnt_q, rxCnt_d, txCnt_q, txCnt_d;
    logic [7:0] rxSh_q, rxSh_d, rxByte_d;
    logic txBusy_q, txBusy_d, txLine_d;
    logic [8:0] txSh_q, txSh_d;

    assign txReady = !txBusy_q;

    always_comb begin
        rxBusy_d = rxBusy_q;
        rxBit_d = rxBit_q;
        rxCnt_d = rxCnt_q;
        rxSh_d = rxSh_q;
        rxByte_d = rxByte;
        rxValid_d = 1'b0;
        if (!rxBusy_q) begin
            if (!rxS2_q) begin
                rxBusy_d = 1'b1;
                rxBit_d = 4'h0;
                rxCnt_d = HALF;
            end
        end else if (rxCnt_q != 16'h0) begin
            rxCnt_d = rxCnt_q - 16'h1;
        end else begin
            rxCnt_d = FULL;
            rxBit_d = rxBit_q + 4'h1;
            if (rxBit_q == 4'h0) begin
                rxBusy_d = !rxS2_q;
            end else if (rxBit_q <= `BLP_LAST_DATA_BIT) begin
                rxSh_d = {rxS2_q, rxSh_q[7:1]};
            end else begin
                // A missing stop bit drops the byte
                rxBusy_d = 1'b0;
                rxValid_d = rxS2_q;
                rxByte_d = rxSh_q;
            end
        end
    end

    always_comb begin
        txBusy_d = txBusy_q;
        txBits_d = txBits_q;
        txCnt_d = txCnt_q;
        txSh_d = txSh_q;
        txLine_d = txPin;
        if (!txBusy_q) begin
            if (txStart) begin
                txBusy_d = 1'b1;
                txLine_d = 1'b0;
                txSh_d = {1'b1, txByte};
                txBits_d = `BLP_FRAME_BITS; // R3
                txCnt_d = FULL;
            end
        end else if (txCnt_q != 16'h0) begin
            txCnt_d = txCnt_q - 16'h1;
        end else if (txBits_q == 4'h0) begin
            txBusy_d = 1'b0;
        end else begin
            txLine_d = txSh_q[0];
            txSh_d = {1'b1, txSh_q[8:1]};
            txBits_d = txBits_q - 4'h1;
            txCnt_d = FULL;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rxS1_q <= 1'b1;
            rxS2_q <= 1'b1;
            rxBusy_q <= 1'b0;
            rxBit_q <= 4'h0;
            rxCnt_q <= 16'h0;
            rxSh_q <= 8'h00;
            rxByte <= 8'h00;
            rxValid <= 1'b0;
            txBusy_q <= 1'b0;
            txBits_q <= 4'h0;
            txCnt_q <= 16'h0;
            txSh_q <= 9'h1ff;
            txPin <= 1'b1;
        end else begin
            rxS1_q <= rxPin;
            rxS2_q <= rxS1_q;
            rxBusy_q <= rxBusy_d;
            rxBit_q <= rxBit_d;
            rxCnt_q <= rxCnt_d;
            rxSh_q <= rxSh_d;
            rxByte <= rxByte_d;
            rxValid <= rxValid_d;
            txBusy_q <= txBusy_d;
            txBits_q <= txBits_d;
            txCnt_q <= txCnt_d;
            txSh_q <= txSh_d;
            txPin <= txLine_d;
        end
    end

    a_tx_start_bit: assert property (@(posedge clk) disable iff (reset) // R3
        txStart && txReady |=> !txPin && !txReady)
        else $error("start bit not sent");
endmodule
`default_nettype wire

// ### core/blp_bootstrap_loader.sv
`timescale 1ns/10ps
`default_nettype none
`include "blp_cfg.svh"
// How it works
// R1 - Strap low: run erase check, then serial
// R2 - Strap high, insecure part: refuse, flash red
// R3 - Serial link 9600 baud, 8N1, full duplex
// R4 - Host sends raw binary bytes only
// R5 - Record: address high, low, four data
// R6 - Each group carries its own fresh address
// R7 - Erasable bank: program first byte only
// R8 - Program, receive and echo groups overlapped
// R9 - Prompt bytes interleave with host bytes
// R10 - Skip programming bytes equal to erased value
// R11 - First two echoed groups are zeros
// R12 - Skipped byte echoes current location contents
// R13 - RAM addresses are written, not programmed
// R14 - Loader RAM range is kept reserved (serial only; the parallel loader writes RAM from 0050 up)
// R15 - Negative high address starts user code
// R16 - Vectors redirect to RAM pseudo-vectors
// R17 - Parallel loader refuses insecure part, flashes
// R18 - Strap low or RAM full: jump start
// R19 - Two-line handshake paces parallel bytes
// R20 - User drive disables external EPROM
// R21 - Host times strap for immediate jump
// R22 - Data in port A, address out
// R23 - Straps at reset select the loader
// R24 - Red and green indicators default off
module blp_bootstrap_loader
    import blp_pkg::*;
#(
    parameter int unsigned BAUD_DIV = `BLP_BAUD_DIV,
    parameter int unsigned FLASH_DIV = `BLP_FLASH_DIV
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic bootMode,
    input wire logic loopExitStrap,
    input wire logic loaderSelectStrap,
    input wire logic secureBit,
    input wire logic verifyDone,
    input wire logic serialRx,
    input wire logic [7:0] parData,
    input wire logic handshakeLineB,
    input wire logic userEpromDisable,
    input wire logic [2:0] vecIdx,
    input wire logic nvAck,
    input wire logic [7:0] nvRdData,
    input wire logic [`BLP_RAM_AW-1:0] ramRdAddr,
    output logic serialTx,
    output logic verifyStart,
    output logic [13:0] parAddr,
    output logic handshakeLineA,
    output logic epromDisableLine,
    output logic redLed,
    output logic greenLed,
    output blp_nv_s nvReq,
    output logic jumpValid,
    output logic [15:0] jumpAddr,
    output logic [15:0] vecTarget,
    output logic [7:0] ramRdData
);
    function automatic blp_region_e blpRegion(input logic [15:0] a);
        if ((a >= `BLP_RAM1_LO && a <= `BLP_RAM1_HI) || (a >= `BLP_RAM2_LO && a <= `BLP_RAM2_HI))
            return RG_RAM;
        if (a >= `BLP_EE_LO && a <= `BLP_EE_HI)
            return RG_EE;
        return RG_OTP;
    endfunction

    // Pin inputs, two flops before use
    logic [12:0] syncA_q, syncB_q;
    blp_strap_s strap;
    logic hsB;
    logic [7:0] parByte;
    assign strap = syncB_q[12:9];
    assign hsB = syncB_q[8];
    assign parByte = syncB_q[7:0];

    blp_state_e state_q, state_d;
    logic [1:0] startCnt_q, startCnt_d;
    logic parMode_q, parMode_d;
    blp_group_t echo_q, echo_d, progData_q, progData_d, res_q, res_d;
    logic [5:0][7:0] rxBuf_q, rxBuf_d;
    logic [2:0] rxCnt_q, rxCnt_d, txCnt_q, txCnt_d;
    logic progStart_q, progStart_d;
    logic [15:0] progAddr_q, progAddr_d, parPtr_q, parPtr_d, jumpAddr_d, vecTarget_d;
    logic [13:0] parAddr_d;
    logic hsA_d, eprDis_d, red_d, green_d, jump_d, verifyStart_d, parWe;
    logic txStart, txReady, rxValid;
    logic [7:0] txByte, rxByte;

    blp_prog_e pst_q, pst_d;
    logic [1:0] idx_q, idx_d;
    blp_nv_s nv_d;
    logic [15:0] curAddr;
    logic [7:0] curData, erased;
    blp_region_e region;
    logic lastByte, engWe, progBusy;

    logic [25:0] flashCnt_q, flashCnt_d;
    logic flash_q, flash_d, flashWrap;

    blp_uart #(.BAUD_DIV(BAUD_DIV)) u_uart (
        .clk(clk),
        .reset(reset),
        .rxPin(serialRx),
        .txStart(txStart),
        .txByte(txByte),
        .txPin(serialTx),
        .txReady(txReady),
        .rxValid(rxValid),
        .rxByte(rxByte)
    );

    blp_ram u_ram (
        .clk(clk),
        .we(engWe | parWe),
        .waddr(parWe ? parPtr_q[`BLP_RAM_AW-1:0] : curAddr[`BLP_RAM_AW-1:0]),
        .wdata(parWe ? parByte : curData),
        .raddr(ramRdAddr),
        .rdata(ramRdData)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // Handshake input resets to its idle high level
            syncA_q <= 13'h100;
            syncB_q <= 13'h100;
        end else begin
            syncA_q <= {bootMode, loopExitStrap, loaderSelectStrap, secureBit,
                handshakeLineB, parData};
            syncB_q <= syncA_q;
        end
    end

    // Flash divider: one toggle per wrap
    always_comb begin
        flashWrap = flashCnt_q == 26'(FLASH_DIV - 1);
        flashCnt_d = flashWrap ? 26'h0 : flashCnt_q + 26'h1;
        flash_d = flash_q ^ flashWrap;
    end

    always_comb begin
        state_d = state_q;
        startCnt_d = startCnt_q;
        parMode_d = parMode_q;
        echo_d = echo_q;
        progData_d = progData_q;
        progAddr_d = progAddr_q;
        rxBuf_d = rxBuf_q;
        rxCnt_d = rxCnt_q;
        txCnt_d = txCnt_q;
        progStart_d = 1'b0;
        parPtr_d = parPtr_q;
        parAddr_d = parAddr;
        hsA_d = handshakeLineA;
        eprDis_d = epromDisableLine;
        red_d = 1'b0; // R24
        green_d = 1'b0;
        jump_d = 1'b0;
        jumpAddr_d = jumpAddr;
        verifyStart_d = 1'b0;
        parWe = 1'b0;
        txStart = 1'b0;
        txByte = echo_q[txCnt_q[1:0]];
        case (state_q)
            S_START: begin
                // Wait until the straps have crossed the synchroniser
                startCnt_d = startCnt_q + 2'h1;
                if (startCnt_q == `BLP_START_WAIT) begin
                    if (!strap.boot) begin
                        state_d = S_HALT;
                    end else if (strap.loopExit && !strap.secure) begin
                        state_d = S_REFUSE; // R2 R17
                    end else if (strap.loopExit) begin
                        parMode_d = !strap.loaderSel; // R23
                        state_d = strap.loaderSel ? S_SER : S_PCHK;
                    end else if (strap.loaderSel) begin
                        verifyStart_d = 1'b1; // R1
                        state_d = S_VERIFY;
                    end else begin
                        state_d = S_HALT;
                    end
                end
            end
            S_VERIFY: begin
                if (verifyDone) begin
                    state_d = S_SER; // R1
                end
            end
            S_REFUSE: begin
                red_d = flash_q; // R2 R17
            end
            S_SER: begin
                green_d = 1'b1;
                // Prompt byte k goes out once k host bytes have arrived
                if (txReady && txCnt_q < `BLP_GROUP_BYTES && rxCnt_q >= txCnt_q) begin
                    txStart = 1'b1; // R9
                    txCnt_d = txCnt_q + 3'h1;
                end
                if (rxValid && rxCnt_q < `BLP_REC_BYTES) begin
                    rxBuf_d[rxCnt_q] = rxByte; // R5
                    rxCnt_d = rxCnt_q + 3'h1;
                    if (rxCnt_q == 3'h0 && rxByte[`BLP_EXEC_BIT] && strap.secure) begin
                        jump_d = 1'b1; // R15
                        jumpAddr_d = `BLP_USER_EXEC_ADDRESS;
                        state_d = S_RUN;
                    end
                end
                if (rxCnt_q == `BLP_REC_BYTES && txCnt_q == `BLP_GROUP_BYTES && !progBusy) begin
                    echo_d = res_q; // R8 R11
                    progAddr_d = {rxBuf_q[0], rxBuf_q[1]}; // R6
                    progData_d = {rxBuf_q[5], rxBuf_q[4], rxBuf_q[3], rxBuf_q[2]};
                    progStart_d = 1'b1;
                    rxCnt_d = 3'h0;
                    txCnt_d = 3'h0;
                end
            end
            S_PCHK: begin
                if (!strap.loopExit || parPtr_q > `BLP_RAM1_HI) begin
                    jump_d = 1'b1; // R18
                    jumpAddr_d = `BLP_RAM_START;
                    state_d = S_RUN;
                end else begin
                    hsA_d = 1'b0; // R19
                    state_d = S_PREQ;
                end
            end
            S_PREQ: begin
                // Tied handshake lines acknowledge through the synchroniser
                if (!hsB) begin
                    parWe = 1'b1; // R19 R22
                    hsA_d = 1'b1;
                    state_d = S_PREL;
                end
            end
            S_PREL: begin
                if (hsB) begin
                    parPtr_d = parPtr_q + 16'h1;
                    parAddr_d = parAddr + 14'h1; // R22
                    state_d = S_PCHK;
                end
            end
            S_RUN: begin
                if (parMode_q) begin
                    eprDis_d = userEpromDisable; // R20
                end
            end
            default: begin
                state_d = S_HALT;
            end
        endcase
        vecTarget_d = (state_q == S_RUN) ?
            `BLP_PVEC_BASE + {13'h0, vecIdx} * `BLP_PVEC_STEP : 16'h0; // R16
    end

    // Programming engine for the group taken in the previous exchange
    always_comb begin
        pst_d = pst_q;
        idx_d = idx_q;
        res_d = res_q;
        nv_d = nvReq;
        nv_d.valid = 1'b0;
        engWe = 1'b0;
        curAddr = progAddr_q + {14'h0, idx_q};
        curData = progData_q[idx_q];
        region = blpRegion(curAddr);
        erased = (region == RG_EE) ? `BLP_EE_ERASED : `BLP_OTP_ERASED; // R10
        lastByte = idx_q == `BLP_LAST_IDX || region == RG_EE; // R7
        progBusy = pst_q != P_IDLE;
        case (pst_q)
            P_IDLE: begin
                if (progStart_q) begin
                    pst_d = P_STEP;
                    idx_d = 2'h0;
                    res_d = '0;
                end
            end
            P_STEP: begin
                if (region == RG_RAM) begin
                    engWe = curAddr > `BLP_RSV_HI; // R13 R14
                    res_d[idx_q] = curData;
                    pst_d = lastByte ? P_IDLE : P_STEP;
                    idx_d = idx_q + 2'h1;
                end else begin
                    nv_d = '{1'b1, curData != erased, curAddr, curData}; // R10
                    pst_d = P_WAIT;
                end
            end
            P_WAIT: begin
                if (nvAck) begin
                    res_d[idx_q] = nvReq.write ? nvReq.data : nvRdData; // R12
                    pst_d = lastByte ? P_IDLE : P_STEP;
                    idx_d = idx_q + 2'h1;
                end
            end
            default: begin
                pst_d = P_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= S_START;
            startCnt_q <= 2'h0;
            parMode_q <= 1'b0;
            echo_q <= '0; // R11
            progData_q <= '0;
            progAddr_q <= 16'h0;
            rxBuf_q <= '0;
            rxCnt_q <= 3'h0;
            txCnt_q <= 3'h0;
            progStart_q <= 1'b0;
            parPtr_q <= `BLP_RAM_START;
            parAddr <= 14'h0;
            handshakeLineA <= 1'b1;
            epromDisableLine <= 1'b0;
            redLed <= 1'b0;
            greenLed <= 1'b0;
            jumpValid <= 1'b0;
            jumpAddr <= 16'h0;
            verifyStart <= 1'b0;
            vecTarget <= 16'h0;
            pst_q <= P_IDLE;
            idx_q <= 2'h0;
            res_q <= '0;
            nvReq <= '0;
            flashCnt_q <= 26'h0;
            flash_q <= 1'b0;
        end else begin
            state_q <= state_d;
            startCnt_q <= startCnt_d;
            parMode_q <= parMode_d;
            echo_q <= echo_d;
            progData_q <= progData_d;
            progAddr_q <= progAddr_d;
            rxBuf_q <= rxBuf_d;
            rxCnt_q <= rxCnt_d;
            txCnt_q <= txCnt_d;
            progStart_q <= progStart_d;
            parPtr_q <= parPtr_d;
            parAddr <= parAddr_d;
            handshakeLineA <= hsA_d;
            epromDisableLine <= eprDis_d;
            redLed <= red_d;
            greenLed <= green_d;
            jumpValid <= jump_d;
            jumpAddr <= jumpAddr_d;
            verifyStart <= verifyStart_d;
            vecTarget <= vecTarget_d;
            pst_q <= pst_d;
            idx_q <= idx_d;
            res_q <= res_d;
            nvReq <= nv_d;
            flashCnt_q <= flashCnt_d;
            flash_q <= flash_d;
        end
    end

    // Helper: groups captured, saturating at two; counted at capture so that
    // the first prompt of the third exchange is already excluded
    logic [1:0] grpCnt_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            grpCnt_q <= 2'h0;
        end else if (progStart_d && grpCnt_q != 2'h2) begin
            grpCnt_q <= grpCnt_q + 2'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_verify_hold: assert property (state_q == S_VERIFY && !verifyDone |=> state_q == S_VERIFY) // R1
        else $error("serial loader entered before verification");
    a_refuse_flash: assert property (state_q == S_REFUSE && $past(state_q) == S_REFUSE // R2
        |-> redLed == $past(flash_q) && !greenLed && !jumpValid)
        else $error("refusal not flashing red");
    a_zero_echo: assert property (txStart && grpCnt_q != 2'h2 |-> txByte == 8'h00) // R11
        else $error("early echo byte not zero");
    a_group_order: assert property (progStart_q |-> $past(rxCnt_q) == 3'h6 // R8
        && $past(txCnt_q) == 3'h4 && rxCnt_q == 3'h0)
        else $error("group started before exchange complete");
    a_erased_skip: assert property (nvReq.valid |-> nvReq.write == (nvReq.data != // R10
        ((blpRegion(nvReq.addr) == RG_EE) ? 8'hff : 8'h00)))
        else $error("erased value programmed");
    a_ee_single: assert property (nvReq.valid && blpRegion(nvReq.addr) == RG_EE // R7
        |-> idx_q == 2'h0 ##[1:1000] pst_q == P_IDLE)
        else $error("dummy byte programmed in erasable bank");
    a_reserved_ram: assert property (engWe |-> curAddr > 16'h008a && region == RG_RAM) // R14
        else $error("write into loader RAM");
    a_exec_jump: assert property (state_q == S_SER && rxValid && rxCnt_q == 3'h0 // R15
        && rxByte[7] && strap.secure |=> jumpValid && jumpAddr == 16'h008b ##1 !jumpValid)
        else $error("execute request not honoured");
    a_strap_exit: assert property (state_q == S_PCHK && !strap.loopExit // R18
        |=> jumpValid && jumpAddr == 16'h0050 && state_q == S_RUN)
        else $error("strap exit did not jump");
endmodule
`default_nettype wire

// ### verification/blp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module blp_host_model import blp_pkg::*; #(
    parameter int BD = 16,
    parameter logic [7:0] RD_VAL = 8'h5a
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic serialTx,
    output logic serialRx,
    input wire blp_nv_s nvReq,
    output logic nvAck,
    output logic [7:0] nvRdData
);
    logic [7:0] rxq[$];
    blp_nv_s nvq[$];
    logic [1:0] pendQ;
    // Outside the ack cycle the read bus shows the inverse, never a stale answer
    assign nvRdData = nvAck ? RD_VAL : ~RD_VAL;
    initial serialRx = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            #1 serialRx = frame[i];
            repeat (BD) @(posedge clk);
        end
    endtask
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge serialTx);
            repeat (BD / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BD) @(posedge clk);
                b[i] = serialTx;
            end
            repeat (BD) @(posedge clk);
            rxq.push_back(b);
        end
    end
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            nvAck <= 1'b0;
            pendQ <= 2'h0;
        end else begin
            pendQ <= {pendQ[0], nvReq.valid};
            nvAck <= pendQ[1];
            if (nvReq.valid) nvq.push_back(nvReq);
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_blp_bootstrap_loader.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
`define WAIT_HI(s, n) for (int k = 0; k < n && s !== 1'b1; k++) begin @(posedge clk); #1; end
module tb_blp_bootstrap_loader import blp_pkg::*;;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic bootMode = 1'b1;
    logic loopExitStrap = 1'b1;
    logic loaderSelectStrap = 1'b1;
    logic secureBit = 1'b0;
    logic verifyDone = 1'b0;
    logic userEpromDisable = 1'b0;
    logic [7:0] parData = 8'hc3;
    logic [2:0] vecIdx = 3'h0;
    logic [9:0] ramRdAddr = 10'h000;
    logic serialRx, serialTx, nvAck, verifyStart, handshakeLineA, handshakeLineB;
    logic epromDisableLine, redLed, greenLed, jumpValid;
    logic [7:0] nvRdData, ramRdData;
    logic [13:0] parAddr;
    logic [15:0] jumpAddr, vecTarget;
    blp_nv_s nvReq;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    // Tied lines: a plain memory source needs no handshake
    assign handshakeLineB = handshakeLineA;
    blp_bootstrap_loader #(.BAUD_DIV(16), .FLASH_DIV(8)) blp_bootstrap_loader_i (.clk, .reset,
        .bootMode, .loopExitStrap, .loaderSelectStrap, .secureBit, .verifyDone, .serialRx,
        .parData, .handshakeLineB, .userEpromDisable, .vecIdx, .nvAck, .nvRdData, .ramRdAddr,
        .serialTx, .verifyStart, .parAddr, .handshakeLineA, .epromDisableLine, .redLed,
        .greenLed, .nvReq, .jumpValid, .jumpAddr, .vecTarget, .ramRdData);
    blp_host_model #(.BD(16)) blp_host_model_i (.clk, .reset, .serialTx, .serialRx, .nvReq,
        .nvAck, .nvRdData);
    task automatic stop_test;
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            stop_test();
        end
    end
    task automatic do_reset(input logic lp, input logic sl, input logic sc);
        reset = 1'b1;
        loopExitStrap = lp;
        loaderSelectStrap = sl;
        secureBit = sc;
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_refuse;
        for (int s = 0; s < 2; s++) begin
            do_reset(1'b1, s[0], 1'b0);
            `WAIT_HI(redLed, 40)
            repeat (4) @(posedge clk);
            #1 `CHK({redLed, greenLed}, 2'h2)
            repeat (8) @(posedge clk);
            #1 `CHK({redLed, greenLed}, 2'h0)
        end
    endtask
    task automatic t_serial;
        logic [7:0] g [4][6];
        logic [7:0] ex [16];
        blp_nv_s nx [5];
        g = '{'{8'h00, 8'h90, 8'h11, 8'h22, 8'h33, 8'h44}, '{8'h10, 8'h00, 8'hab, 8'h00, 8'hcd,
            8'h00}, '{8'h01, 8'h00, 8'hff, 8'h01, 8'h02, 8'h03}, '{8'h00, 8'h94, 8'h55, 8'h66,
            8'h77, 8'h88}};
        ex = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h11, 8'h22, 8'h33,
            8'h44, 8'hab, 8'h5a, 8'hcd, 8'h5a};
        nx = '{'{1'b1, 1'b1, 16'h1000, 8'hab}, '{1'b1, 1'b0, 16'h1001, 8'h00}, '{1'b1, 1'b1,
            16'h1002, 8'hcd}, '{1'b1, 1'b0, 16'h1003, 8'h00}, '{1'b1, 1'b0, 16'h0100, 8'h00}};
        do_reset(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 5; i++) begin
            for (int k = 0; k < 3000 && blp_host_model_i.rxq.size() <= 4 * i; k++)
                @(posedge clk);
            if (i < 4)
                for (int b = 0; b < 6; b++) blp_host_model_i.send_byte(g[i][b]);
        end
        `CHK(greenLed, 1'b1)
        for (int i = 0; i < 16; i++) `CHK(blp_host_model_i.rxq[i], ex[i])
        `CHK(blp_host_model_i.nvq.size(), 5)
        for (int i = 0; i < 5; i++) begin
            `CHK(blp_host_model_i.nvq[i][24:8], nx[i][24:8])
            if (nx[i].write) `CHK(blp_host_model_i.nvq[i].data, nx[i].data)
        end
        fork
            blp_host_model_i.send_byte(8'h80);
            begin
                `WAIT_HI(jumpValid, 400)
                `CHK({jumpValid, jumpAddr}, 17'h1008b)
            end
        join
        #1 ramRdAddr = 10'h090;
        repeat (2) @(posedge clk);
        #1 `CHK(ramRdData, 8'h11)
        ramRdAddr = 10'h097;
        repeat (2) @(posedge clk);
        #1 `CHK(ramRdData, 8'h88)
        for (int i = 0; i < 6; i++) begin
            vecIdx = 3'(i);
            repeat (2) @(posedge clk);
            #1 `CHK(vecTarget, 16'h02ee + 16'(3 * i))
        end
    endtask
    task automatic t_parallel;
        for (int m = 0; m < 2; m++) begin
            do_reset(1'b1, 1'b0, 1'b1);
            if (m == 1) loopExitStrap = 1'b0;
            `WAIT_HI(jumpValid, 2000)
            `CHK({jumpValid, jumpAddr, redLed, greenLed}, 19'h40140)
            if (m == 0) begin
                `CHK(parAddr, 14'h00b0)
                ramRdAddr = 10'h0ff;
                repeat (2) @(posedge clk);
                #1 `CHK(ramRdData, 8'hc3)
            end
            userEpromDisable = ~userEpromDisable;
            repeat (2) @(posedge clk);
            #1 `CHK(epromDisableLine, userEpromDisable)
        end
    endtask
    task automatic t_verify;
        do_reset(1'b0, 1'b1, 1'b1);
        `WAIT_HI(verifyStart, 10)
        `CHK(verifyStart, 1'b1)
        repeat (20) @(posedge clk);
        #1 `CHK(greenLed, 1'b0)
        verifyDone = 1'b1;
        @(posedge clk);
        #1 verifyDone = 1'b0;
        `WAIT_HI(greenLed, 10)
        `CHK(greenLed, 1'b1)
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 `CHK({serialTx, handshakeLineA, redLed, greenLed, jumpValid}, 5'h18)
        t_refuse();
        t_serial();
        t_parallel();
        t_verify();
        stop_test();
    end
endmodule
`default_nettype wire
